// [rtl/wsl_loader.sv]
/*
 waveform segment loader: APB slave holding segment table, sample memories
 (internal and extended), write/read sessions and a simple playback port.
 assumes APB signals synchronous to clk_sys; one wait state per access.
*/
`timescale 1ns/100ps
module wsl_loader
   import wsl_pkg::*;
#(
   parameter int NCH = 4,
   parameter int NSEG = 16,
   parameter int DEPTH = 1024,
   parameter int GRAN = 64,
   parameter int SW = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [SW-1:0] wave_out,
   output logic mark1,
   output logic mark2
);
   localparam int AW = $clog2(DEPTH);
   localparam int SB = $clog2(NSEG);
   localparam int CW = $clog2(NCH);
   localparam int EW = SW + 2;
   localparam int ALB = $clog2(2 * GRAN);

   function automatic logic [SB:0] first_free(input logic [NSEG-1:0] used);
      logic [SB:0] r;
      r = '0;
      for (int i = NSEG - 1; i >= 0; i--) begin
         if (!used[i]) r = {1'b1, SB'(i)};
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] ctrl_q, cmd_q, offs_q, len_q, err_q, prdata_q;
   logic pready_q, pslverr_q;
   wsl_state_t st_q;
   logic [AW:0] base_q [NSEG];
   logic [AW:0] slen_q [NSEG];
   logic [NCH-1:0] def_q [NSEG];
   logic [NSEG-1:0] sext_q;
   logic [AW:0] bump_q [2];
   logic [AW:0] hole_b_q [2];
   logic [AW:0] hole_l_q [2];
   logic [EW-1:0] imem [DEPTH];
   logic [EW-1:0] xmem [DEPTH];
   logic [AW:0] ptr_q, lend_q, pp_q;
   logic [31:0] rem_q;
   logic ph_q, xs_q, bin_q, lval_q;
   logic [SW-1:0] hold_q, wave_q;
   logic [SB-1:0] sseg_q, lseg_q, newseg_q;
   logic [1:0] mk_q;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire acc = ce & psel & penable & ~pready_q;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire a_ctrl = paddr == OFF_CTRL;
   wire a_cmd = paddr == OFF_CMD;
   wire a_offs = paddr == OFF_OFFS;
   wire a_len = paddr == OFF_LEN;
   wire a_data = paddr == OFF_DATA;
   wire a_stat = paddr == OFF_STAT;
   wire a_err = paddr == OFF_ERR;
   wire mapped = a_ctrl | a_cmd | a_offs | a_len | a_data | a_stat | a_err;
   wire cmd_w = wr & a_cmd;

   // ------------------------------------------------------------
   // command checks
   // ------------------------------------------------------------
   wire [2:0] op_w = pwdata[CMD_OP+:3];
   wire [CW-1:0] ch_w = pwdata[CMD_CH+:CW];
   wire [SB-1:0] seg_w = pwdata[CMD_SEG+:SB];
   wire [NCH-1:0] msrc_w = ctrl_q[CTRL_MSRC+:NCH];
   wire ext_w = msrc_w[ch_w];
   wire run = ctrl_q[CTRL_RUN];
   wire ilv = ctrl_q[CTRL_ILV];
   wire rd_ok = ~run;
   wire wr_ok = ~run | ctrl_q[CTRL_DYN];
   // extended needs even vector multiples, internal any offset
   wire align_ok = ~ext_w | (offs_q[ALB-1:0] == '0);
   wire seg_ok = def_q[seg_w][ch_w];
   wire [31:0] slen_w = 32'(slen_q[seg_w]);
   // offset 0 restarts a segment so a full rewrite is allowed
   wire asc_ok = ~(lval_q & (seg_w == lseg_q) & (offs_q != '0) & (offs_q < 32'(lend_q)));
   wire rd_fit = ({1'b0, offs_q} + {1'b0, len_q}) <= {1'b0, slen_w};
   wire [AW:0] need_l = len_q[AW:0];
   wire len_ok = (len_q != '0) & (len_q <= 32'(DEPTH));
   wire [AW:0] hole_b_w = hole_b_q[ext_w];
   wire [AW:0] hole_l_w = hole_l_q[ext_w];
   wire [AW:0] bump_w = bump_q[ext_w];
   wire hole_fit = hole_l_w >= need_l;
   wire bump_fit = ({1'b0, bump_w} + {1'b0, need_l}) <= (AW + 2)'(DEPTH);
   logic [NSEG-1:0] used_w;
   for (genvar i = 0; i < NSEG; i++) begin : g_used
      assign used_w[i] = |def_q[i];
   end
   wire [SB:0] ff_w = first_free(used_w);
   wire [SB-1:0] fid = ff_w[SB-1:0];
   wire [AW:0] alloc_b = hole_fit ? hole_b_w : bump_w;

   // ------------------------------------------------------------
   // sample path
   // ------------------------------------------------------------
   wire [AW:0] sl_s = slen_q[sseg_q];
   wire [AW:0] ptr1 = ptr_q + (AW + 1)'(1);
   wire [AW-1:0] a0 = AW'(base_q[sseg_q] + ptr_q);
   wire [AW-1:0] a1 = AW'(base_q[sseg_q] + ptr1);
   wire w_act = wr & a_data & (st_q == ST_WR);
   wire r_act = rd & a_data & (st_q == ST_RD);
   // comma list interleaved: sample word is held until its marker arrives
   wire w_hold = ilv & ~bin_q & ~ph_q;
   wire two = bin_q & ~ilv;
   wire [SW-1:0] s0 = (ilv & ~bin_q) ? hold_q : pwdata[SW-1:0];
   wire [1:0] mk = ~ilv ? 2'h0 : bin_q ? pwdata[SW+:2] : pwdata[1:0];
   wire fit0 = ptr_q < sl_s;
   wire fit1 = ptr1 < sl_s;
   wire we0 = w_act & ~w_hold & fit0;
   wire we1 = w_act & two & fit1 & fit0;
   wire ovf = w_act & ~w_hold & (~fit0 | (two & ~fit1));
   wire [EW-1:0] ent = xs_q ? xmem[a0] : imem[a0];
   wire adv = ~ilv | ph_q;
   wire [31:0] rd_word = adv & ilv ? 32'(ent[SW+:2]) : 32'(ent[SW-1:0]);

   logic [31:0] cmd_err;
   always_comb begin
      cmd_err = ERR_NONE;
      unique case (op_w)
         OP_DEF: begin
            if (!len_ok) cmd_err = ERR_PARAM;
            else if (!ff_w[SB] || !(hole_fit || bump_fit)) cmd_err = ERR_MEM;
         end
         OP_WR: begin
            if (!wr_ok) cmd_err = ERR_CONFLICT;
            else if (!seg_ok) cmd_err = ERR_RANGE;
            else if (!align_ok || !asc_ok) cmd_err = ERR_PARAM;
            else if (offs_q > slen_w) cmd_err = ERR_TOO_MUCH;
         end
         OP_RD: begin
            if (!rd_ok) cmd_err = ERR_CONFLICT;
            else if (!seg_ok || !rd_fit) cmd_err = ERR_RANGE;
         end
         OP_DEL: begin
            if (!seg_ok) cmd_err = ERR_RANGE;
         end
         OP_PURGE: cmd_err = ERR_NONE;
         default: cmd_err = ERR_PARAM;
      endcase
   end
   wire [31:0] ev_err = ovf ? ERR_TOO_MUCH : cmd_w ? cmd_err : ERR_NONE;
   wire go = cmd_w & (cmd_err == ERR_NONE);
   wire def_go = go & (op_w == OP_DEF);
   wire del_go = go & (op_w == OP_DEL);
   wire pur_go = go & (op_w == OP_PURGE);
   wire wr_go = go & (op_w == OP_WR);
   wire rd_go = go & (op_w == OP_RD) & (len_q != '0);

   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (a_ctrl) rmux = ctrl_q;
      if (a_cmd) rmux = cmd_q;
      if (a_offs) rmux = offs_q;
      if (a_len) rmux = len_q;
      if (a_data && st_q == ST_RD) rmux = rd_word;
      if (a_stat) rmux = (32'(newseg_q) << STAT_SEG) | 32'(st_q);
      if (a_err) rmux = err_q;
   end

   // ------------------------------------------------------------
   // apb and software registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         pready_q <= acc;
         pslverr_q <= acc & ~mapped;
         if (rd) prdata_q <= rmux;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= CTRL_RST;
         cmd_q <= 32'h0000_0000;
         offs_q <= 32'h0000_0000;
         len_q <= 32'h0000_0000;
         err_q <= ERR_NONE;
      end else if (ce) begin
         if (wr & a_ctrl) ctrl_q <= pwdata;
         if (cmd_w) cmd_q <= pwdata;
         if (wr & a_offs) offs_q <= pwdata;
         if (wr & a_len) len_q <= pwdata;
         // a new error wins over a clear in the same cycle
         if (ev_err != ERR_NONE) err_q <= ev_err;
         else if (wr & a_err) err_q <= ERR_NONE;
      end
   end

   // ------------------------------------------------------------
   // sessions
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_IDLE;
         ptr_q <= '0;
         rem_q <= 32'h0000_0000;
         ph_q <= 1'b0;
         hold_q <= '0;
         sseg_q <= '0;
         xs_q <= 1'b0;
         bin_q <= 1'b0;
      end else if (ce) begin
         if (cmd_w) begin
            st_q <= wr_go ? ST_WR : rd_go ? ST_RD : ST_IDLE;
            ptr_q <= offs_q[AW:0];
            rem_q <= len_q;
            ph_q <= 1'b0;
            sseg_q <= seg_w;
            xs_q <= ext_w;
            bin_q <= pwdata[CMD_BIN];
         end else if (w_act) begin
            if (w_hold) hold_q <= pwdata[SW-1:0];
            ph_q <= w_hold;
            if (we1) ptr_q <= ptr_q + (AW + 1)'(2);
            else if (we0) ptr_q <= ptr1;
         end else if (r_act) begin
            ph_q <= ilv & ~ph_q;
            if (adv) begin
               ptr_q <= ptr1;
               rem_q <= rem_q - 32'h0000_0001;
               if (rem_q == 32'h0000_0001) st_q <= ST_IDLE;
            end
         end
      end
   end

   // samples overwrite in place, markers ride in the top two bits
   always_ff @(posedge clk_sys) begin
      if (we0 && xs_q) xmem[a0] <= {mk, s0};
      if (we0 && !xs_q) imem[a0] <= {mk, s0};
      if (we1 && xs_q) xmem[a1] <= {2'h0, pwdata[SW+:SW]};
      if (we1 && !xs_q) imem[a1] <= {2'h0, pwdata[SW+:SW]};
   end

   // ------------------------------------------------------------
   // segment table and allocator
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NSEG; i++) begin
            def_q[i] <= '0;
            base_q[i] <= '0;
            slen_q[i] <= '0;
         end
         sext_q <= '0;
         newseg_q <= '0;
         lval_q <= 1'b0;
         lseg_q <= '0;
         lend_q <= '0;
      end else if (ce) begin
         if (pur_go) begin
            for (int i = 0; i < NSEG; i++) def_q[i] <= '0;
            lval_q <= 1'b0;
         end else if (def_go) begin
            // extended segments appear on every extended channel
            def_q[fid] <= ext_w ? msrc_w : NCH'(1) << ch_w;
            base_q[fid] <= alloc_b;
            slen_q[fid] <= need_l;
            sext_q[fid] <= ext_w;
            newseg_q <= fid;
         end else if (del_go) begin
            def_q[seg_w] <= '0;
            if (seg_w == lseg_q) lval_q <= 1'b0;
         end
         if (wr_go) begin
            lval_q <= 1'b1;
            lseg_q <= seg_w;
            lend_q <= offs_q[AW:0];
         end else if (w_act && (we0 || we1)) begin
            lend_q <= we1 ? ptr_q + (AW + 1)'(2) : ptr1;
         end
      end
   end

   // only the latest freed region of each memory is remembered; older holes are lost until purge
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int m = 0; m < 2; m++) begin
            bump_q[m] <= '0;
            hole_b_q[m] <= '0;
            hole_l_q[m] <= '0;
         end
      end else if (ce) begin
         if (pur_go) begin
            for (int m = 0; m < 2; m++) begin
               bump_q[m] <= '0;
               hole_l_q[m] <= '0;
            end
         end else if (def_go && hole_fit) begin
            hole_b_q[ext_w] <= hole_b_w + need_l;
            hole_l_q[ext_w] <= hole_l_w - need_l;
         end else if (def_go) begin
            bump_q[ext_w] <= bump_w + need_l;
         end else if (del_go) begin
            hole_b_q[sext_q[seg_w]] <= base_q[seg_w];
            hole_l_q[sext_q[seg_w]] <= slen_q[seg_w];
         end
      end
   end

   // ------------------------------------------------------------
   // playback of the segment named in the last command
   // ------------------------------------------------------------
   wire [SB-1:0] pseg = cmd_q[CMD_SEG+:SB];
   wire [CW-1:0] pch = cmd_q[CMD_CH+:CW];
   wire [AW:0] plen = slen_q[pseg];
   wire [AW-1:0] pa_w = AW'(base_q[pseg] + pp_q);
   wire [EW-1:0] pent = msrc_w[pch] ? xmem[pa_w] : imem[pa_w];
   wire [AW:0] pp1 = pp_q + (AW + 1)'(1);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pp_q <= '0;
         wave_q <= '0;
         mk_q <= MK_LO;
      end else if (ce) begin
         if (!run || plen == '0) pp_q <= '0;
         else pp_q <= (pp1 >= plen) ? '0 : pp1;
         wave_q <= run ? pent[SW-1:0] : '0;
         mk_q <= run ? pent[SW+:2] : MK_LO;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign wave_out = wave_q;
   assign mark1 = mk_q[0];
   assign mark2 = mk_q[1];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   sequence s_read_cmd;
      cmd_w && op_w == OP_RD;
   endsequence
   sequence s_last_pop;
      r_act && adv && rem_q == 32'h0000_0001;
   endsequence

   a_read_refused: assert property (s_read_cmd and run |=> err_q == ERR_CONFLICT && st_q == ST_IDLE)
      else $error("read accepted while running");
   a_write_refused: assert property (cmd_w && op_w == OP_WR && run && !ctrl_q[CTRL_DYN] |=> err_q == ERR_CONFLICT && st_q == ST_IDLE)
      else $error("write accepted while running");
   a_dyn_write_ok: assert property (cmd_w && op_w == OP_WR && cmd_err == ERR_NONE |=> st_q == ST_WR)
      else $error("valid write refused");
   a_overflow_err: assert property (ovf |=> err_q == ERR_TOO_MUCH)
      else $error("overflow not reported");
   a_ext_align: assert property (cmd_w && op_w == OP_WR && ext_w && offs_q[ALB-1:0] != '0 |=> st_q == ST_IDLE && err_q != ERR_NONE)
      else $error("misaligned extended offset accepted");
   a_int_any_off: assert property (cmd_w && op_w == OP_WR && !ext_w && wr_ok && seg_ok && asc_ok && offs_q <= slen_w |=> st_q == ST_WR)
      else $error("internal offset refused");
   a_read_count: assert property (s_read_cmd ##0 (cmd_err == ERR_NONE && len_q != '0) |=> rem_q == $past(len_q) && st_q == ST_RD)
      else $error("read length not loaded");
   a_read_end: assert property (s_last_pop |=> st_q == ST_IDLE)
      else $error("read ran past requested count");
   a_marker_hi: assert property (run && ce && pent[SW+:2] == MK_HI |=> mark1 && mark2)
      else $error("marker 3 not driven high");
   a_marker_lo: assert property (run && ce && pent[SW+:2] == MK_LO |=> !mark1 && !mark2)
      else $error("marker 0 not driven low");
   a_ext_define: assert property (def_go && ext_w |=> def_q[$past(fid)] == $past(msrc_w))
      else $error("extended segment not shared");
   a_hole_reuse: assert property (def_go && hole_fit |=> base_q[$past(fid)] == $past(hole_b_w))
      else $error("freed space not reused");
endmodule // wsl_loader

// [common/wsl_pkg.sv]
/*
 constants for the waveform segment loader: APB register offsets, field
 positions, command and error codes, state encoding.
 assumes a 32-bit APB master and one 200 MHz clock.
*/
// How it works
// - rewritten positions replace stored samples
// - data past segment end: error -223
// - readback only while generation halted
// - writes when halted or running dynamic
// - channel memory source picks internal/extended
// - converter mode picks plain or interleaved
// - vector size equals memory granularity
// - internal memory takes any offset
// - offset counts waveform samples, not markers
// - read returns exactly requested sample count
// - binary block or comma list data
// - marker value 3 drives both high
// - marker value 0 drives both low
// - new segments reuse freed space; the code keeps only the latest freed region per memory
// - extended define spans all extended channels
package wsl_pkg;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_OFFS = 8'h08;
   localparam logic [7:0] OFF_LEN = 8'h0C;
   localparam logic [7:0] OFF_DATA = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_ERR = 8'h18;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_DYN = 1;
   localparam int CTRL_ILV = 2;
   localparam int CTRL_MSRC = 4;
   localparam int CMD_OP = 0;
   localparam int CMD_BIN = 3;
   localparam int CMD_CH = 4;
   localparam int CMD_SEG = 8;
   localparam int STAT_SEG = 8;
   localparam logic [2:0] OP_DEF = 3'h0;
   localparam logic [2:0] OP_WR = 3'h1;
   localparam logic [2:0] OP_RD = 3'h2;
   localparam logic [2:0] OP_DEL = 3'h3;
   localparam logic [2:0] OP_PURGE = 3'h4;
   localparam logic [31:0] ERR_NONE = 32'h0000_0000;
   localparam logic [31:0] ERR_CONFLICT = 32'hFFFF_FF23;
   localparam logic [31:0] ERR_RANGE = 32'hFFFF_FF22;
   localparam logic [31:0] ERR_TOO_MUCH = 32'hFFFF_FF21;
   localparam logic [31:0] ERR_PARAM = 32'hFFFF_FF20;
   localparam logic [31:0] ERR_MEM = 32'hFFFF_FF1F;
   localparam logic [1:0] MK_HI = 2'h3;
   localparam logic [1:0] MK_LO = 2'h0;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WR = 3'b010,
      ST_RD = 3'b100
   } wsl_state_t;
endpackage

// [dv/wsl_host_model.sv]
/*
 host side model: an apb master that issues register accesses for the
 loader. assumes the slave answers with pready and that clk_sys is free running.
*/
`timescale 1ns/100ps
module wsl_host_model #(
   parameter int GRAN = 64
) (
   input wire logic clk_sys,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   int timeouts;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      timeouts = 0;
   end
   // extended offsets are always an even count of vectors
   function automatic logic [31:0] ext_offs(input int pairs);
      return 32'(pairs * 2 * GRAN);
   endfunction
   // ----------------------------------------
   // one apb transfer, held until pready or 50 cycles
   // ----------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         timeouts++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data lines never keep the last value
      pwdata <= ~d;
   endtask
endmodule // wsl_host_model

// [dv/wsl_loader_tb.sv]
/*
 self-checking bench for the segment loader, driving it through the host model.
 assumes the loader's register map and error codes from wsl_pkg.
*/
`timescale 1ns/100ps
module wsl_loader_tb;
   import wsl_pkg::*;
   localparam int GRAN = 64;
   localparam logic [1:0] MKS [8] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
   logic clk_sys, rstn, ce, psel, penable, pwrite, pready, pslverr, mark1, mark2;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] wave_out;
   int errors, check_count;
   wsl_loader #(.GRAN(GRAN)) wsl_loader_inst (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wave_out(wave_out),
      .mark1(mark1), .mark2(mark2));
   wsl_host_model #(.GRAN(GRAN)) wsl_host_model_inst (.clk_sys(clk_sys), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      wsl_host_model_inst.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      logic [31:0] q;
      logic er;
      wsl_host_model_inst.xfer(1'b0, a, 32'h0, q, er);
      chk(w, q & m, e);
   endtask
   task automatic cmd(input logic [2:0] op, input logic bin, input logic [1:0] ch,
                      input logic [3:0] seg);
      wr(OFF_CMD, {20'h0, seg, 2'h0, ch, bin, op});
   endtask
   // error register is read then cleared
   task automatic err_is(input string w, input logic [31:0] e);
      rdc(w, OFF_ERR, 32'hFFFF_FFFF, e);
      wr(OFF_ERR, 32'h0);
   endtask
   task automatic rd_set(input logic [31:0] offs, input logic [31:0] len,
                         input logic [1:0] ch, input logic [3:0] seg);
      wr(OFF_OFFS, offs);
      wr(OFF_LEN, len);
      cmd(OP_RD, 1'b0, ch, seg);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [31:0] q;
      logic e;
      chk("wave idle", {14'h0, wave_out, mark2, mark1}, 32'h0);
      rdc("ctrl", OFF_CTRL, 32'hFFFF_FFFF, CTRL_RST);
      rdc("stat", OFF_STAT, 32'h0000_0F07, 32'h1);
      wsl_host_model_inst.xfer(1'b0, 8'h1C, 32'h0, q, e);
      chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
   endtask
   task automatic t_plain;
      wr(OFF_CTRL, 32'h0);
      wr(OFF_LEN, 32'h8);
      cmd(OP_DEF, 1'b0, 2'h0, 4'h0);
      rdc("def stat", OFF_STAT, 32'h0000_0F07, 32'h1);
      wr(OFF_OFFS, 32'h0);
      cmd(OP_WR, 1'b0, 2'h0, 4'h0);
      rdc("wr stat", OFF_STAT, 32'h7, 32'h2);
      for (int i = 0; i < 9; i++)
         wr(OFF_DATA, 32'h100 + i);
      err_is("too much", ERR_TOO_MUCH);
      wr(OFF_OFFS, 32'h0); // whole segment restarts at offset 0
      cmd(OP_WR, 1'b0, 2'h0, 4'h0);
      wr(OFF_DATA, 32'h200);
      wr(OFF_DATA, 32'h201);
      wr(OFF_OFFS, 32'h3);
      cmd(OP_WR, 1'b0, 2'h0, 4'h0);
      wr(OFF_DATA, 32'h303);
      err_is("odd internal", ERR_NONE);
      wr(OFF_OFFS, 32'h2); // descending section on purpose
      cmd(OP_WR, 1'b0, 2'h0, 4'h0);
      wr(OFF_DATA, 32'h3FF);
      err_is("descending", ERR_PARAM);
      rd_set(32'h0, 32'h8, 2'h0, 4'h0);
      for (int i = 0; i < 8; i++)
         rdc("sample", OFF_DATA, 32'hFFFF, i < 2 ? 32'h200 + i : i == 3 ? 32'h303 :
             32'h100 + i);
      rdc("rd done", OFF_STAT, 32'h7, 32'h1);
      rd_set(32'h4, 32'h5, 2'h0, 4'h0);
      err_is("read past end", ERR_RANGE);
      wr(OFF_OFFS, 32'h0);
      cmd(OP_WR, 1'b1, 2'h0, 4'h0);
      wr(OFF_DATA, 32'h0411_0410);
      rd_set(32'h0, 32'h2, 2'h0, 4'h0);
      rdc("bin lo", OFF_DATA, 32'hFFFF, 32'h410);
      rdc("bin hi", OFF_DATA, 32'hFFFF, 32'h411);
   endtask
   task automatic t_run;
      wr(OFF_CTRL, 32'h1);
      cmd(OP_RD, 1'b0, 2'h0, 4'h0);
      err_is("rd running", ERR_CONFLICT);
      cmd(OP_WR, 1'b0, 2'h0, 4'h0);
      err_is("wr running", ERR_CONFLICT);
      wr(OFF_CTRL, 32'h3);
      cmd(OP_WR, 1'b0, 2'h0, 4'h0);
      err_is("wr dynamic", ERR_NONE);
      rdc("dyn stat", OFF_STAT, 32'h7, 32'h2);
      cmd(OP_RD, 1'b0, 2'h0, 4'h0);
      err_is("rd dynamic", ERR_CONFLICT);
      wr(OFF_CTRL, 32'h0);
   endtask
   task automatic t_marker;
      int n;
      logic [31:0] w;
      wr(OFF_CTRL, 32'h4);
      wr(OFF_OFFS, 32'h0);
      cmd(OP_WR, 1'b0, 2'h0, 4'h0);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_DATA, 32'h500 + i);
         wr(OFF_DATA, {30'h0, MKS[i]});
      end
      wr(OFF_OFFS, 32'h4);
      cmd(OP_WR, 1'b1, 2'h0, 4'h0);
      for (int i = 4; i < 8; i++)
         wr(OFF_DATA, {14'h0, MKS[i], 16'h500 + 16'(i)});
      rd_set(32'h0, 32'h8, 2'h0, 4'h0);
      for (int i = 0; i < 8; i++) begin
         rdc("ilv sample", OFF_DATA, 32'hFFFF, 32'h500 + i);
         rdc("ilv marker", OFF_DATA, 32'h3, {30'h0, MKS[i]});
      end
      wr(OFF_CTRL, 32'h5);
      n = 0;
      repeat (64) begin
         @(posedge clk_sys);
         if (wave_out[15:8] === 8'h05) begin
            n++;
            chk("marker pins", {30'h0, mark2, mark1}, {30'h0, MKS[wave_out[2:0]]});
         end
      end
      // playback moves every cycle, so a held clock enable must freeze it
      ce <= 1'b0;
      @(posedge clk_sys);
      w = {14'h0, wave_out, mark2, mark1};
      repeat (4) @(posedge clk_sys);
      chk("frozen", {14'h0, wave_out, mark2, mark1}, w);
      ce <= 1'b1;
      chk("playback", 32'(n > 8), 32'h1);
      wr(OFF_CTRL, 32'h0);
      repeat (4) @(posedge clk_sys);
      chk("stopped", {14'h0, wave_out, mark2, mark1}, 32'h0);
   endtask
   task automatic t_ext;
      wr(OFF_CTRL, 32'h30);
      wr(OFF_LEN, 32'h100);
      cmd(OP_DEF, 1'b0, 2'h0, 4'h0);
      rdc("ext id", OFF_STAT, 32'h0F00, 32'h100);
      wr(OFF_OFFS, 32'(GRAN)); // one vector only, refused on purpose
      cmd(OP_WR, 1'b0, 2'h1, 4'h1);
      wr(OFF_DATA, 32'h666);
      err_is("odd vector", ERR_PARAM);
      wr(OFF_OFFS, wsl_host_model_inst.ext_offs(1));
      cmd(OP_WR, 1'b0, 2'h1, 4'h1);
      wr(OFF_DATA, 32'h777);
      err_is("even vector", ERR_NONE);
      rd_set(32'(2 * GRAN), 32'h1, 2'h1, 4'h1);
      rdc("ext sample", OFF_DATA, 32'hFFFF, 32'h777);
      rd_set(32'h0, 32'h1, 2'h2, 4'h1);
      err_is("internal ch", ERR_RANGE);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_LEN, 32'h8);
      cmd(OP_PURGE, 1'b0, 2'h0, 4'h0); // purge before ordered creation
      cmd(OP_DEF, 1'b0, 2'h0, 4'h0);
      rdc("purged id", OFF_STAT, 32'h0F00, 32'h0);
      cmd(OP_DEF, 1'b0, 2'h0, 4'h0);
      rdc("second id", OFF_STAT, 32'h0F00, 32'h100);
      // freeing id 0 leaves a hole that the next define must take
      cmd(OP_DEL, 1'b0, 2'h0, 4'h0);
      cmd(OP_DEF, 1'b0, 2'h0, 4'h0);
      rdc("reused id", OFF_STAT, 32'h0F00, 32'h0);
      err_is("reuse define", ERR_NONE);
      cmd(3'h7, 1'b0, 2'h0, 4'h0);
      err_is("bad op", ERR_PARAM);
      wr(OFF_LEN, 32'h0);
      cmd(OP_DEF, 1'b0, 2'h0, 4'h0);
      err_is("zero length", ERR_PARAM);
      wr(OFF_LEN, 32'h3F0);
      cmd(OP_DEF, 1'b0, 2'h0, 4'h0);
      err_is("fill memory", ERR_NONE);
      wr(OFF_LEN, 32'h8);
      cmd(OP_DEF, 1'b0, 2'h0, 4'h0);
      err_is("memory full", ERR_MEM);
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      errors = 0;
      check_count = 0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_plain();
      t_run();
      t_marker();
      t_ext();
      chk("bus hangs", 32'(wsl_host_model_inst.timeouts), 32'h0);
      final_report();
   end
   // whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      final_report();
   end
endmodule // wsl_loader_tb
